//--- logic/rsi_seq.sv
/*
 * Reset initialization sequencer: power-on reset, open-drain hard and
 * soft reset lines, strap latching and strap driver control.
 * Assumes all pin inputs are synchronous to mclk; the open-drain wires are
 * resolved outside from the output enables.
 */
// What this block does
// - Hold hard and soft asserted 512 sync periods; soft releases 16 later.
// - Stop driving strap pins within 4 ns of hard reset assertion.
// - Drive strap pins again only 1 sync period after hard release.
// - In host mode derive the sync period from the latched divide strap.
// - Hard and soft lines are open-drain, only ever pulled low.
`timescale 1ns/1ps
`include "rsi_seq_map.svh"

module rsi_seq
    import rsi_seq_pkg::*;
#(
    parameter logic [3:0] DIV_LOW_RATIO = 4'h1,
    parameter logic [3:0] DIV_HIGH_RATIO = 4'h2
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic agentMode,
    input wire logic syncTickIn,
    input wire logic powerOnResetIn_n,
    input wire logic hardResetLineIn_n,
    output logic hardResetLineOut_n,
    output logic hardResetLineOe,
    input wire logic softResetLineIn_n,
    output logic softResetLineOut_n,
    output logic softResetLineOe,
    input wire rsi_strap_s strapIn,
    output rsi_strap_s strapOut,
    output logic strapOe,
    output logic syncTick,
    output logic seqBusy
);

    localparam logic [9:0] HOLD_LAST = 10'(`RSI_HOLD_TICKS - 1);
    localparam logic [9:0] GAP_LAST = 10'(`RSI_GAP_TICKS - 1);
    localparam logic [5:0] DETECT_CNT = 6'(`RSI_DETECT_TICKS);
    localparam logic [1:0] RESUME_CNT = 2'(`RSI_RESUME_TICKS + 1);

    rsi_state_s s_q;
    rsi_state_s s_d;
    logic [3:0] ratio;

    always_comb begin
        s_d = s_q;
        ratio = s_q.strap.clkDivide ? DIV_HIGH_RATIO : DIV_LOW_RATIO;
        // sync clock enable: own divider in host mode, outside pulse in agent mode
        if (agentMode) begin
            s_d.tick = syncTickIn;
            s_d.divCnt = 4'h0;
        end else if (s_q.divCnt >= ratio - 4'h1) begin
            s_d.tick = 1'b1;
            s_d.divCnt = 4'h0;
        end else begin
            s_d.tick = 1'b0;
            s_d.divCnt = s_q.divCnt + 4'h1;
        end
        s_d.porPrev = powerOnResetIn_n;
        // outside requests are qualified by their length in sync periods
        if (hardResetLineIn_n || s_q.hardDrv) begin
            s_d.hardReqCnt = 6'h00;
        end else if (s_q.tick && s_q.hardReqCnt < DETECT_CNT) begin
            s_d.hardReqCnt = s_q.hardReqCnt + 6'h01;
        end
        if (softResetLineIn_n || s_q.softDrv) begin
            s_d.softReqCnt = 6'h00;
        end else if (s_q.tick && s_q.softReqCnt < DETECT_CNT) begin
            s_d.softReqCnt = s_q.softReqCnt + 6'h01;
        end
        if (s_q.tick) begin
            s_d.tickCnt = s_q.tickCnt + 10'h001;
        end
        case (s_q.state)
            RsiPorHold: begin
                s_d.tickCnt = 10'h000;
                if (powerOnResetIn_n && !s_q.porPrev) begin
                    s_d.strap = strapIn;
                    s_d.state = RsiHold;
                end
            end
            RsiHold: begin
                if (s_q.tick && s_q.tickCnt == HOLD_LAST) begin
                    s_d.tickCnt = 10'h000;
                    s_d.state = RsiGap;
                end
            end
            RsiGap: begin
                if (s_q.tick && s_q.tickCnt == GAP_LAST) begin
                    s_d.state = RsiRun;
                end
            end
            RsiSoftOnly: begin
                if (s_q.tick && s_q.tickCnt == HOLD_LAST) begin
                    s_d.state = RsiRun;
                end
            end
            RsiRun: begin
                s_d.tickCnt = 10'h000;
                if (s_q.hardReqCnt == DETECT_CNT) begin
                    s_d.state = RsiHold;
                end else if (s_q.softReqCnt == DETECT_CNT) begin
                    s_d.state = RsiSoftOnly;
                end
            end
            default: begin
                s_d.state = RsiPorHold;
            end
        endcase
        if (!powerOnResetIn_n) begin
            s_d.state = RsiPorHold;
        end
        s_d.hardDrv = (s_d.state == RsiPorHold) || (s_d.state == RsiHold);
        s_d.softDrv = s_d.hardDrv || (s_d.state == RsiGap) || (s_d.state == RsiSoftOnly);
        // straps may be driven only after a full sync period of hard release
        if (!hardResetLineIn_n || s_d.hardDrv) begin
            s_d.resumeCnt = 2'h0;
        end else if (s_q.tick && s_q.resumeCnt < RESUME_CNT) begin
            s_d.resumeCnt = s_q.resumeCnt + 2'h1;
        end
        s_d.strapDrv = (s_d.resumeCnt == RESUME_CNT) && (s_d.state == RsiRun);
        if (!reset_n) begin
            s_d = '0;
            s_d.state = RsiPorHold;
            s_d.hardDrv = 1'b1;
            s_d.softDrv = 1'b1;
            s_d.strap.resetSource = `RSI_SRC_RST;
            s_d.strap.clkDivide = `RSI_DIV_RST;
        end
    end

    always_ff @(posedge mclk) begin
        s_q <= s_d;
    end

    // open-drain: the data level is always low, only the enable moves
    assign hardResetLineOut_n = 1'b0;
    assign softResetLineOut_n = 1'b0;
    assign hardResetLineOe = s_q.hardDrv;
    assign softResetLineOe = s_q.softDrv;
    assign strapOut = s_q.strap;
    // a flop cannot let go within a few ns, so the live line level gates it
    assign strapOe = s_q.strapDrv && hardResetLineIn_n;
    assign syncTick = s_q.tick;
    assign seqBusy = s_q.state != RsiRun;

    // checking helpers: sync periods counted while each condition holds
    logic [9:0] hardHeld;
    logic [4:0] gapHeld;
    logic [1:0] relHeld;
    always_ff @(posedge mclk) begin
        if (!reset_n || !hardResetLineOe) begin
            hardHeld <= 10'h000;
        end else if (syncTick && hardHeld != 10'h3ff) begin
            hardHeld <= hardHeld + 10'h001;
        end
        if (!reset_n || hardResetLineOe || !softResetLineOe) begin
            gapHeld <= 5'h00;
        end else if (syncTick && gapHeld != 5'h1f) begin
            gapHeld <= gapHeld + 5'h01;
        end
        if (!reset_n || !hardResetLineIn_n) begin
            relHeld <= 2'h0;
        end else if (syncTick && relHeld != 2'h3) begin
            relHeld <= relHeld + 2'h1;
        end
    end

    property p_hardHold;
        @(posedge mclk) disable iff (!reset_n)
        $fell(hardResetLineOe) && powerOnResetIn_n |-> $past(hardHeld) >= 10'(`RSI_HOLD_TICKS - 1);
    endproperty
    a_hardHold: assert property (p_hardHold) else $error("hard line released too early");

    property p_softGap;
        @(posedge mclk) disable iff (!reset_n)
        $fell(softResetLineOe) && powerOnResetIn_n
            |-> $past(gapHeld) >= 5'(`RSI_GAP_TICKS - 1);
    endproperty
    a_softGap: assert property (p_softGap) else $error("soft line released too soon after hard");

    property p_strapOff;
        @(posedge mclk) disable iff (!reset_n)
        !hardResetLineIn_n |-> !strapOe;
    endproperty
    a_strapOff: assert property (p_strapOff) else $error("straps driven during hard reset");

    property p_strapResume;
        @(posedge mclk) disable iff (!reset_n)
        strapOe |-> relHeld >= 2'(`RSI_RESUME_TICKS);
    endproperty
    a_strapResume: assert property (p_strapResume) else $error("straps driven too soon after release");

    property p_divHigh;
        @(posedge mclk) disable iff (!reset_n)
        !agentMode && strapOut.clkDivide && syncTick ##1 !agentMode |-> !syncTick;
    endproperty
    a_divHigh: assert property (p_divHigh) else $error("sync period wrong for divide strap");

    property p_divLow;
        @(posedge mclk) disable iff (!reset_n)
        !agentMode && !strapOut.clkDivide && $past(!agentMode) && $past(!strapOut.clkDivide) && $past(reset_n)
            |-> syncTick;
    endproperty
    a_divLow: assert property (p_divLow) else $error("sync tick missing in undivided host mode");

    property p_openDrain;
        @(posedge mclk) disable iff (!reset_n)
        hardResetLineOe |-> !hardResetLineOut_n && !hardResetLineIn_n;
    endproperty
    a_openDrain: assert property (p_openDrain) else $error("reset line not pulled low while driven");

    property p_softOpenDrain;
        @(posedge mclk) disable iff (!reset_n)
        softResetLineOe |-> !softResetLineOut_n && !softResetLineIn_n;
    endproperty
    a_softOpenDrain: assert property (p_softOpenDrain) else $error("soft line not pulled low while driven");

    property p_strapLatch;
        @(posedge mclk) disable iff (!reset_n)
        $rose(powerOnResetIn_n) ##1 powerOnResetIn_n |-> strapOut == $past(strapIn, 1) ##1 $stable(strapOut);
    endproperty
    a_strapLatch: assert property (p_strapLatch) else $error("straps not latched at power-on release");

endmodule // rsi_seq

//--- logic/rsi_seq_map.svh
/*
 * Timing counts, strap widths and reset values for the reset
 * initialization sequencer. Definitions only; included by bare name.
 */
`ifndef RSI_SEQ_MAP_SVH
`define RSI_SEQ_MAP_SVH

// clock of the block
`define RSI_MCLK_NS 50
// least assertion of an external hard or soft request, in sync clock periods
`define RSI_DETECT_TICKS 32
// least time the block holds both lines asserted, in sync clock periods
`define RSI_HOLD_TICKS 512
// least gap from hard release to soft release, in sync clock periods
`define RSI_GAP_TICKS 16
// least wait after hard release before the straps are driven again
`define RSI_RESUME_TICKS 1
// latest turn-off of the strap drivers after hard assertion
`define RSI_STRAP_OFF_NS 4
// width of the reset-source strap
`define RSI_SRC_W 3
// reset value of the latched straps
`define RSI_SRC_RST 3'h0
`define RSI_DIV_RST 1'b0

`endif

//--- logic/rsi_seq_pkg.sv
/*
 * Types of the reset initialization sequencer.
 * Assumes rsi_seq_map.svh holds the numeric constants.
 */
`include "rsi_seq_map.svh"

package rsi_seq_pkg;

    typedef enum logic [2:0] {
        RsiPorHold,
        RsiHold,
        RsiGap,
        RsiSoftOnly,
        RsiRun
    } rsi_state_e;

    typedef struct packed {
        logic [`RSI_SRC_W-1:0] resetSource;
        logic clkDivide;
    } rsi_strap_s;

    typedef struct packed {
        rsi_state_e state;
        logic [9:0] tickCnt;
        logic [3:0] divCnt;
        logic tick;
        logic porPrev;
        logic [5:0] hardReqCnt;
        logic [5:0] softReqCnt;
        logic [1:0] resumeCnt;
        logic hardDrv;
        logic softDrv;
        logic strapDrv;
        rsi_strap_s strap;
    } rsi_state_s;

endpackage

//--- tb/rsi_board.sv
/* board side of the sequencer: open-drain reset wires and strap pins.
   assumes the bench sets the board's pulls and strap levels at the falling edge */
`timescale 1ns/1ps
module rsi_board
    import rsi_seq_pkg::*;
(
    input wire logic hardPull,
    input wire logic softPull,
    input wire logic hardOe,
    input wire logic softOe,
    input wire logic strapOe,
    input wire rsi_strap_s strapOut,
    input wire rsi_strap_s strapDrv,
    output logic hardWire_n,
    output logic softWire_n,
    output rsi_strap_s strapPins
);
    // a wire reads high only when nobody pulls it
    assign hardWire_n = !(hardPull || hardOe);
    assign softWire_n = !(softPull || softOe);
    // board holds the straps whenever the device has let go of them
    assign strapPins = strapOe ? strapOut : strapDrv;
endmodule // rsi_board

//--- tb/rsi_seq_bench.sv
/* self-checking bench of the reset sequencer with the board model.
   assumes the sequencer's contract of one sync tick per period */
`timescale 1ns/1ps
module rsi_seq_bench
    import rsi_seq_pkg::*;
;
    logic mclk = 0, reset_n = 0, agentMode = 0, syncTickIn = 0, porIn_n = 0, hardPull = 0, softPull = 0;
    logic hardOe, softOe, strapOe, syncTick, seqBusy, hardWire_n, softWire_n;
    logic hardOut_n, softOut_n;
    rsi_strap_s strapDrv = '0, strapOut, strapPins;
    int errors = 0, total_checks = 0, ratio = 1, tcnt = 0;
    logic [31:0] rng = 32'h0000001f;

    rsi_seq DUT (.mclk(mclk), .reset_n(reset_n), .agentMode(agentMode), .syncTickIn(syncTickIn),
        .powerOnResetIn_n(porIn_n), .hardResetLineIn_n(hardWire_n), .hardResetLineOut_n(hardOut_n),
        .hardResetLineOe(hardOe), .softResetLineIn_n(softWire_n), .softResetLineOut_n(softOut_n),
        .softResetLineOe(softOe), .strapIn(strapPins), .strapOut(strapOut), .strapOe(strapOe),
        .syncTick(syncTick), .seqBusy(seqBusy));
    rsi_board board (.hardPull(hardPull), .softPull(softPull), .hardOe(hardOe), .softOe(softOe),
        .strapOe(strapOe), .strapOut(strapOut), .strapDrv(strapDrv), .hardWire_n(hardWire_n),
        .softWire_n(softWire_n), .strapPins(strapPins));

    initial forever #25 mclk = ~mclk;
    // agent mode sync clock: one tick every third cycle
    always @(negedge mclk) begin
        tcnt <= (tcnt + 1) % 3;
        syncTickIn <= agentMode && tcnt == 0;
    end

    function automatic logic [31:0] xs();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng;
    endfunction

    task automatic fail(string msg);
        errors++;
        $display("[FAIL] %0t %s", $time, msg);
    endtask
    task automatic chkBit(logic got, logic exp, string msg);
        total_checks++;
        if (got !== exp) fail(msg);
    endtask
    task automatic chkStrap(rsi_strap_s got, rsi_strap_s exp, string msg);
        total_checks++;
        if (got !== exp) fail(msg);
    endtask
    task automatic chkSpan(int got, int lo, int hi, string msg);
        total_checks++;
        if (got < lo || got > hi) fail(msg);
    endtask
    // 0 hard enable, 1 soft enable, 2 strap enable, 3 busy
    function automatic logic pick(int w);
        case (w)
            0: return hardOe;
            1: return softOe;
            2: return strapOe;
            default: return seqBusy;
        endcase
    endfunction
    task automatic waitVal(int w, logic v, output int n);
        n = 0;
        while (pick(w) !== v && n < 4000) begin
            @(negedge mclk);
            n++;
        end
        if (n >= 4000) fail("wait limit reached");
    endtask

    task automatic runSeq(logic div, logic agent);
        rsi_strap_s s;
        logic [31:0] r;
        int n;
        int c;
        r = xs();
        s = {r[2:0], div};
        agentMode = agent;
        ratio = agent ? 3 : (div ? 2 : 1);
        porIn_n = 0;
        strapDrv = s;
        repeat (32 * ratio + 2) @(negedge mclk);
        chkBit(hardOe & softOe, 1'b1, "lines free in power-on reset");
        porIn_n = 1;
        @(negedge mclk);
        chkStrap(strapOut, s, "straps not latched");
        waitVal(0, 1'b0, n);
        chkSpan(n, 512 * ratio - 4, 512 * ratio + 4, "hard hold length");
        chkBit(strapOe, 1'b0, "straps driven at hard release");
        strapDrv = ~s;
        waitVal(1, 1'b0, n);
        chkSpan(n, 16 * ratio - 3, 16 * ratio + 3, "soft gap length");
        chkBit(seqBusy, 1'b0, "busy after soft release");
        waitVal(2, 1'b1, n);
        chkSpan(n, 0, 20 * ratio, "straps never driven again");
        chkStrap(strapPins, s, "latched straps lost");
        c = 0;
        repeat (12) begin
            @(negedge mclk);
            c += syncTick;
        end
        chkSpan(c, 12 / ratio, 12 / ratio, "sync tick rate");
        $display("sequence div %0d agent %0d done", div, agent);
    endtask

    task automatic extReq(logic hard, int ticks, logic hit);
        int n;
        if (hard) hardPull = 1;
        else softPull = 1;
        #1;
        chkBit(strapOe, !hard, "strap drivers on with hard wire low");
        chkBit(hardOut_n | softOut_n, 1'b0, "open-drain data not low");
        repeat (ticks) @(negedge mclk);
        hardPull = 0;
        softPull = 0;
        repeat (3) @(negedge mclk);
        chkBit(hard ? hardOe : softOe, hit, "request length response");
        chkBit(softOe, hit, "soft line with request");
        waitVal(3, 1'b0, n);
        waitVal(2, 1'b1, n);
        chkBit(strapOe, 1'b1, "straps not back after request");
        $display("request hard %0d ticks %0d done", hard, ticks);
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    initial begin
        #(20000 * 50);
        fail("watchdog expired");
        summarize();
    end

    initial begin
        repeat (2) @(negedge mclk);
        chkBit(hardOe & softOe, 1'b1, "lines free in reset");
        reset_n = 1;
        runSeq(1'b0, 1'b0);
        extReq(1'b1, 30, 1'b0);
        extReq(1'b1, 34, 1'b1);
        extReq(1'b0, 30, 1'b0);
        extReq(1'b0, 34, 1'b1);
        runSeq(1'b1, 1'b0);
        runSeq(1'b0, 1'b1);
        summarize();
    end
endmodule // rsi_seq_bench
